// [pcg_pkg.sv]
/*
  Shared constants for the peripheral clock gate and software reset slice:
  register offsets, field positions, reset values and power mode codes.
  Assumes byte addressing on a 32-bit register port, one word per register.
*/
package pcg_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] PCG_ADDR_SW_RESET_0 = 12'h040;
  localparam logic [11:0] PCG_ADDR_DEEP_GATE = 12'h128;
  localparam logic [11:0] PCG_ADDR_CLOCK_CFG = 12'h200;
  localparam logic [11:0] PCG_ADDR_IRQ_STATUS = 12'h204;
  localparam logic [11:0] PCG_ADDR_IRQ_MASK = 12'h208;
  localparam logic [11:0] PCG_ADDR_PORT_STATE = 12'h20C;
  localparam logic [11:0] PCG_ADDR_FAULT_INFO = 12'h210;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PCG_NUM_PORTS = 5;
  localparam int PCG_BIT_PORT_A = 0;
  localparam int PCG_BIT_PORT_E = 4;
  localparam int PCG_BIT_WATCHDOG = 3;
  localparam int PCG_BIT_CONVERTER = 16;
  localparam int PCG_BIT_ACG = 0;

  // Writable bits of the software reset register
  localparam logic [31:0] PCG_SW_RESET_IMPL = 32'h0001_0008;
  // Writable bits of the deep-sleep gate register
  localparam logic [31:0] PCG_DEEP_GATE_IMPL = 32'h0000_001F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] PCG_SW_RESET_RST = 32'h0000_0000;
  localparam logic [4:0] PCG_DEEP_GATE_RST = 5'h00;
  localparam logic [4:0] PCG_MASK_RST = 5'h00;
  localparam logic PCG_ACG_RST = 1'b0;

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCG_MODE_RUN,
    PCG_MODE_SLEEP,
    PCG_MODE_DEEP
  } pcg_mode_t;

endpackage

// [pcg_sticky.sv]
/*
  Sticky event flags, cleared by writing one; a set in the same cycle
  as a clear wins. Assumes single-cycle event pulses on core_clk.
*/
`timescale 1ns/10ps
module pcg_sticky
  import pcg_pkg::*;
#(
  parameter int WIDTH = 5
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clr_in,
  output logic [WIDTH-1:0] flag_reg
);

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= '0;
    end else begin
      // Set beats clear so no event is lost
      flag_reg <= (flag_reg & ~clr_in) | set_in;
    end
  end

endmodule

// [pcg_port_gate.sv]
/*
  Clock gate control and bus-fault check for one I/O port.
  Assumes access strobes are one cycle long and synchronous to core_clk.
*/
`timescale 1ns/10ps
module pcg_port_gate
  import pcg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic gate_sel,
  input wire logic access_req,
  output logic clk_en_reg,
  output logic access_ok,
  output logic access_fault
);

  // ----------------------------------------------------------------
  // Gate enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_en_reg <= 1'b0;
    end else begin
      clk_en_reg <= gate_sel;
    end
  end

  // ----------------------------------------------------------------
  // Access check against the enable the port actually has
  // ----------------------------------------------------------------
  assign access_ok = access_req & clk_en_reg;
  assign access_fault = access_req & ~clk_en_reg;

endmodule

// [pcg_clock_reset_ctrl.sv]
/*
  Peripheral clock gate and software reset control: register file,
  per-port clock enables, bus-fault detection, peripheral reset holds
  and a fault interrupt.
  Assumes a single-master register port on core_clk, a power mode input
  from the power controller, and the run and sleep gate vectors and the
  first capability word supplied from elsewhere in system control.
  Register port: one-cycle strobes, never a read and a write together,
  read data in the cycle after the read strobe and zero otherwise.
  Port access requests are one-cycle pulses, one per attempted access,
  judged against the enable each port already has; the bus fault and
  the access grant are combinational so the fabric can end the access
  in the same cycle.
  Clock enables and reset holds are registered; the clock gate cells
  and the reset synchronisers of each peripheral sit outside this
  block and take them as levels.
  The power mode input is taken as synchronous and is expected to
  change only while the affected ports are idle.
*/
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module pcg_clock_reset_ctrl
  import pcg_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NPORT = PCG_NUM_PORTS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [31:0] reg_rd_data,
  input wire pcg_mode_t power_mode,
  input wire logic [NPORT-1:0] run_port_clock_gate,
  input wire logic [NPORT-1:0] sleep_port_clock_gate,
  input wire logic [31:0] capability_mask_1,
  input wire logic [NPORT-1:0] port_access_req,
  output logic [NPORT-1:0] port_access_ok,
  output logic port_bus_fault,
  output logic [NPORT-1:0] port_clk_en,
  output logic converter_reset,
  output logic watchdog_reset,
  output logic irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0] software_reset_control_0_reg;
  logic [NPORT-1:0] deep_sleep_port_clock_gate_reg;
  logic auto_clock_gating_select_reg;
  logic [NPORT-1:0] irq_mask_reg;
  logic [NPORT-1:0] irq_status;
  logic [NPORT-1:0] fault_seen_reg;
  logic [15:0] fault_count_reg;
  logic [31:0] reg_rd_data_reg;
  logic converter_reset_reg;
  logic watchdog_reset_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit_sw_reset;
  logic hit_deep_gate;
  logic hit_clock_cfg;
  logic hit_irq_status;
  logic hit_irq_mask;
  logic hit_fault_info;

  assign hit_sw_reset = (reg_addr == ADDR_W'(PCG_ADDR_SW_RESET_0));
  assign hit_deep_gate = (reg_addr == ADDR_W'(PCG_ADDR_DEEP_GATE));
  assign hit_clock_cfg = (reg_addr == ADDR_W'(PCG_ADDR_CLOCK_CFG));
  assign hit_irq_status = (reg_addr == ADDR_W'(PCG_ADDR_IRQ_STATUS));
  assign hit_irq_mask = (reg_addr == ADDR_W'(PCG_ADDR_IRQ_MASK));
  assign hit_fault_info = (reg_addr == ADDR_W'(PCG_ADDR_FAULT_INFO));

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // One strobe per writable register keeps every always block to its own concern
  logic wr_sw_reset;
  logic wr_deep_gate;
  logic wr_clock_cfg;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic wr_fault_info;

  assign wr_sw_reset = reg_wr_en & hit_sw_reset;
  assign wr_deep_gate = reg_wr_en & hit_deep_gate;
  assign wr_clock_cfg = reg_wr_en & hit_clock_cfg;
  assign wr_irq_status = reg_wr_en & hit_irq_status;
  assign wr_irq_mask = reg_wr_en & hit_irq_mask;
  assign wr_fault_info = reg_wr_en & hit_fault_info;

  // ----------------------------------------------------------------
  // Software reset register
  // ----------------------------------------------------------------
  // Only the capability-present, implemented bits can ever be one,
  // so reserved fields stay zero; the read path also masks with PCG_SW_RESET_IMPL
  logic [31:0] sw_reset_next;

  assign sw_reset_next = reg_wr_data & capability_mask_1 & PCG_SW_RESET_IMPL;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      software_reset_control_0_reg <= PCG_SW_RESET_RST;
    end else if (wr_sw_reset) begin
      software_reset_control_0_reg <= sw_reset_next;
    end
  end

  // ----------------------------------------------------------------
  // Deep-sleep gate register
  // ----------------------------------------------------------------
  // Reserved bits are dropped at the write, so they always read zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      deep_sleep_port_clock_gate_reg <= PCG_DEEP_GATE_RST;
    end else if (wr_deep_gate) begin
      deep_sleep_port_clock_gate_reg <= reg_wr_data[PCG_BIT_PORT_E:PCG_BIT_PORT_A];
    end
  end

  // ----------------------------------------------------------------
  // Clock configuration: auto gating select
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_clock_gating_select_reg <= PCG_ACG_RST;
    end else if (wr_clock_cfg) begin
      auto_clock_gating_select_reg <= reg_wr_data[PCG_BIT_ACG];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_reg <= PCG_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= reg_wr_data[NPORT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Gate selection by power mode
  // ----------------------------------------------------------------
  // Without auto gating the run set stays in force in every mode, so
  // a port cannot stop merely because the core went to sleep
  logic [NPORT-1:0] gate_sel;

  always_comb begin
    gate_sel = run_port_clock_gate;
    case (power_mode)
      PCG_MODE_RUN: begin
        gate_sel = run_port_clock_gate;
      end
      PCG_MODE_SLEEP: begin
        if (auto_clock_gating_select_reg) begin
          gate_sel = sleep_port_clock_gate;
        end
      end
      PCG_MODE_DEEP: begin
        if (auto_clock_gating_select_reg) begin
          gate_sel = deep_sleep_port_clock_gate_reg;
        end
      end
      default: begin
        gate_sel = run_port_clock_gate;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Per-port gates
  // ----------------------------------------------------------------
  logic [NPORT-1:0] port_fault;

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      pcg_port_gate u_gate (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .gate_sel(gate_sel[gi]),
        .access_req(port_access_req[gi]),
        .clk_en_reg(port_clk_en[gi]),
        .access_ok(port_access_ok[gi]),
        .access_fault(port_fault[gi])
      );
    end
  endgenerate

  assign port_bus_fault = |port_fault;

  // ----------------------------------------------------------------
  // Fault events: sticky status and interrupt
  // ----------------------------------------------------------------
  logic [NPORT-1:0] status_clr;

  assign status_clr = wr_irq_status ? reg_wr_data[NPORT-1:0] : '0;

  pcg_sticky #(
    .WIDTH(NPORT)
  ) u_status (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .set_in(port_fault),
    .clr_in(status_clr),
    .flag_reg(irq_status)
  );

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Combinational so the line rises in the cycle the status bit sets
  logic [NPORT-1:0] irq_pending;

  assign irq_pending = irq_status & irq_mask_reg;
  assign irq = |irq_pending;

  // ----------------------------------------------------------------
  // Fault diagnostics
  // ----------------------------------------------------------------
  // Counter saturates so a storm of faults never wraps to a small value
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_count_reg <= 16'h0000;
    end else if (wr_fault_info) begin
      fault_count_reg <= 16'h0000;
    end else if (port_bus_fault && (fault_count_reg != 16'hFFFF)) begin
      fault_count_reg <= fault_count_reg + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_seen_reg <= '0;
    end else if (port_bus_fault) begin
      fault_seen_reg <= port_fault;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral reset holds
  // ----------------------------------------------------------------
  // Registered so a peripheral never sees a glitch from the bus decode
  logic converter_hold;
  logic watchdog_hold;

  assign converter_hold = software_reset_control_0_reg[PCG_BIT_CONVERTER];
  assign watchdog_hold = software_reset_control_0_reg[PCG_BIT_WATCHDOG];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      converter_reset_reg <= 1'b0;
    end else begin
      converter_reset_reg <= converter_hold;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_reset_reg <= 1'b0;
    end else begin
      watchdog_reset_reg <= watchdog_hold;
    end
  end

  assign converter_reset = converter_reset_reg;
  assign watchdog_reset = watchdog_reset_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] fault_info_word;
  logic [31:0] rd_mux;

  always_comb begin
    fault_info_word = 32'h0000_0000;
    fault_info_word[15:0] = fault_count_reg;
    fault_info_word[16+NPORT-1:16] = fault_seen_reg;
  end

  // Unmapped offsets and reserved fields read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      ADDR_W'(PCG_ADDR_SW_RESET_0): begin
        rd_mux = software_reset_control_0_reg & PCG_SW_RESET_IMPL;
      end
      ADDR_W'(PCG_ADDR_DEEP_GATE): begin
        rd_mux[NPORT-1:0] = deep_sleep_port_clock_gate_reg;
      end
      ADDR_W'(PCG_ADDR_CLOCK_CFG): begin
        rd_mux[PCG_BIT_ACG] = auto_clock_gating_select_reg;
      end
      ADDR_W'(PCG_ADDR_IRQ_STATUS): begin
        rd_mux[NPORT-1:0] = irq_status;
      end
      ADDR_W'(PCG_ADDR_IRQ_MASK): begin
        rd_mux[NPORT-1:0] = irq_mask_reg;
      end
      ADDR_W'(PCG_ADDR_PORT_STATE): begin
        rd_mux[NPORT-1:0] = port_clk_en;
      end
      ADDR_W'(PCG_ADDR_FAULT_INFO): begin
        rd_mux = fault_info_word;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Data stand for exactly the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rd_data_reg <= 32'h0000_0000;
    end else if (reg_rd_en) begin
      reg_rd_data_reg <= rd_mux;
    end else begin
      reg_rd_data_reg <= 32'h0000_0000;
    end
  end

  assign reg_rd_data = reg_rd_data_reg;

endmodule

// [pcg_clock_reset_ctrl_properties.sv]
/*
  Port-level checks for the clock gate and software reset slice.
  Assumes binding into pcg_clock_reset_ctrl, seeing its ports only.
*/
`timescale 1ns/10ps
module pcg_clock_reset_ctrl_properties
  import pcg_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int NPORT = PCG_NUM_PORTS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [31:0] reg_rd_data,
  input wire pcg_mode_t power_mode,
  input wire logic [NPORT-1:0] run_port_clock_gate,
  input wire logic [NPORT-1:0] sleep_port_clock_gate,
  input wire logic [31:0] capability_mask_1,
  input wire logic [NPORT-1:0] port_access_req,
  input wire logic [NPORT-1:0] port_access_ok,
  input wire logic port_bus_fault,
  input wire logic [NPORT-1:0] port_clk_en,
  input wire logic converter_reset,
  input wire logic watchdog_reset,
  input wire logic irq
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_fault_gated_port: assert property (port_bus_fault == |(port_access_req & ~port_clk_en))
    else $error("Bus fault does not match gated access");
  chk_ok_clocked_port: assert property (port_access_ok == (port_access_req & port_clk_en))
    else $error("Access ok does not match clocked port");
  chk_watchdog_masked: assert property ((reg_wr_en && reg_addr == PCG_ADDR_SW_RESET_0) |->
    ##2 watchdog_reset == $past(reg_wr_data[3] & capability_mask_1[3], 2))
    else $error("Watchdog reset not masked write value");
  chk_converter_masked: assert property ((reg_wr_en && reg_addr == PCG_ADDR_SW_RESET_0) |->
    ##2 converter_reset == $past(reg_wr_data[16] & capability_mask_1[16], 2))
    else $error("Converter reset not masked write value");
  chk_watchdog_held: assert property (!$stable(watchdog_reset) |->
    $past(reg_wr_en && reg_addr == PCG_ADDR_SW_RESET_0, 2))
    else $error("Watchdog reset moved without a write");
  chk_sw_reserved_zero: assert property ($past(reg_rd_en && reg_addr == PCG_ADDR_SW_RESET_0) |->
    (reg_rd_data & ~PCG_SW_RESET_IMPL) == 32'h0000_0000)
    else $error("Reserved reset bits read nonzero");
  chk_gate_reserved_zero: assert property ($past(reg_rd_en && reg_addr == PCG_ADDR_DEEP_GATE) |->
    (reg_rd_data & ~PCG_DEEP_GATE_IMPL) == 32'h0000_0000)
    else $error("Reserved gate bits read nonzero");
  chk_irq_rise_cause: assert property ($rose(irq) |-> $past(port_bus_fault) || $past(reg_wr_en))
    else $error("Interrupt rose without a fault");
endmodule

bind pcg_clock_reset_ctrl pcg_clock_reset_ctrl_properties #(.ADDR_W(ADDR_W), .NPORT(NPORT)) chk_u (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .power_mode(power_mode),
  .run_port_clock_gate(run_port_clock_gate), .sleep_port_clock_gate(sleep_port_clock_gate),
  .capability_mask_1(capability_mask_1), .port_access_req(port_access_req), .port_access_ok(port_access_ok),
  .port_bus_fault(port_bus_fault), .port_clk_en(port_clk_en), .converter_reset(converter_reset),
  .watchdog_reset(watchdog_reset), .irq(irq)
);

// [pcg_clock_reset_ctrl_bench.sv]
/*
  Self-checking bench for the clock gate and software reset slice.
  Assumes design files and checker are compiled ahead of it.
*/
`timescale 1ns/10ps
module pcg_clock_reset_ctrl_bench
  import pcg_pkg::*;
();
  // ----
  // Signals
  // ----
  logic core_clk = 1'b0;
  logic rst_b;
  logic [11:0] reg_addr;
  logic [31:0] reg_wr_data;
  logic reg_wr_en;
  logic reg_rd_en;
  logic [31:0] reg_rd_data;
  pcg_mode_t power_mode;
  logic [4:0] run_port_clock_gate;
  logic [4:0] sleep_port_clock_gate;
  logic [31:0] capability_mask_1;
  logic [4:0] port_access_req;
  logic [4:0] port_access_ok;
  logic port_bus_fault;
  logic [4:0] port_clk_en;
  logic converter_reset;
  logic watchdog_reset;
  logic irq;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;

  always #10 core_clk = ~core_clk;

  pcg_clock_reset_ctrl dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .power_mode(power_mode),
    .run_port_clock_gate(run_port_clock_gate), .sleep_port_clock_gate(sleep_port_clock_gate),
    .capability_mask_1(capability_mask_1), .port_access_req(port_access_req), .port_access_ok(port_access_ok),
    .port_bus_fault(port_bus_fault), .port_clk_en(port_clk_en), .converter_reset(converter_reset),
    .watchdog_reset(watchdog_reset), .irq(irq)
  );

  // ----
  // Shared tasks
  // ----
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("Checked %0d, failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk) {reg_wr_en, reg_addr, reg_wr_data} <= {1'b1, a, d};
    @(posedge core_clk) reg_wr_en <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk) {reg_rd_en, reg_addr} <= {1'b1, a};
    @(posedge core_clk) reg_rd_en <= 1'b0;
    #1 check(reg_rd_data, exp);
  endtask

  // Long enough for either gate path to land
  task settle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task access(input logic [4:0] v, input logic f, input logic i);
    @(posedge core_clk) port_access_req <= v;
    #1 check(port_bus_fault, f);
    check(port_access_ok, f ? 5'h00 : v);
    @(posedge core_clk) port_access_req <= 5'h00;
    #1 check(irq, i);
  endtask

  // ----
  // Scenarios
  // ----
  task t_reset_values;
    rd(PCG_ADDR_SW_RESET_0, 32'h0000_0000);
    rd(PCG_ADDR_DEEP_GATE, 32'h0000_0000);
    check(port_clk_en, 5'h00);
    rd(12'h3FC, 32'h0000_0000);
  endtask

  task t_sw_reset;
    @(posedge core_clk) capability_mask_1 <= 32'hFFFF_FFFF;
    wr(PCG_ADDR_SW_RESET_0, 32'hFFFF_FFFF);
    rd(PCG_ADDR_SW_RESET_0, 32'h0001_0008);
    settle;
    check({converter_reset, watchdog_reset}, 2'b11);
    @(posedge core_clk) capability_mask_1 <= 32'h0000_0008;
    wr(PCG_ADDR_SW_RESET_0, 32'hFFFF_FFFF);
    rd(PCG_ADDR_SW_RESET_0, 32'h0000_0008);
    settle;
    check({converter_reset, watchdog_reset}, 2'b01);
    wr(PCG_ADDR_SW_RESET_0, 32'h0000_0000);
    settle;
    check(watchdog_reset, 1'b0);
  endtask

  task t_gating;
    wr(PCG_ADDR_CLOCK_CFG, 32'h0000_0001);
    rd(PCG_ADDR_CLOCK_CFG, 32'h0000_0001);
    @(posedge core_clk) power_mode <= PCG_MODE_DEEP;
    wr(PCG_ADDR_DEEP_GATE, 32'hFFFF_FFFF);
    rd(PCG_ADDR_DEEP_GATE, 32'h0000_001F);
    settle;
    check(port_clk_en, 5'h1F);
    wr(PCG_ADDR_DEEP_GATE, 32'h0000_0012);
    settle;
    check(port_clk_en, 5'h12);
    @(posedge core_clk) begin
      power_mode <= PCG_MODE_RUN;
      run_port_clock_gate <= 5'h05;
    end
    settle;
    check(port_clk_en, 5'h05);
    @(posedge core_clk) begin
      power_mode <= PCG_MODE_SLEEP;
      sleep_port_clock_gate <= 5'h0A;
    end
    settle;
    check(port_clk_en, 5'h0A);
    wr(PCG_ADDR_CLOCK_CFG, 32'h0000_0000);
    settle;
    check(port_clk_en, 5'h05);
    rd(PCG_ADDR_CLOCK_CFG, 32'h0000_0000);
    rd(PCG_ADDR_PORT_STATE, 32'h0000_0005);
  endtask

  // Ports A and C clocked by now, so B and D fault
  task t_fault_irq;
    wr(PCG_ADDR_IRQ_MASK, 32'h0000_001F);
    access(5'h01, 1'b0, 1'b0);
    access(5'h02, 1'b1, 1'b1);
    rd(PCG_ADDR_IRQ_STATUS, 32'h0000_0002);
    wr(PCG_ADDR_IRQ_STATUS, 32'h0000_0002);
    #1 check(irq, 1'b0);
    wr(PCG_ADDR_IRQ_MASK, 32'h0000_0000);
    access(5'h08, 1'b1, 1'b0);
    wr(PCG_ADDR_IRQ_MASK, 32'h0000_0008);
    #1 check(irq, 1'b1);
    wr(PCG_ADDR_IRQ_STATUS, 32'h0000_0008);
    #1 check(irq, 1'b0);
    rd(PCG_ADDR_FAULT_INFO, 32'h0008_0002);
    wr(PCG_ADDR_FAULT_INFO, 32'h0000_0000);
    rd(PCG_ADDR_FAULT_INFO, 32'h0008_0000);
  endtask

  // ----
  // Run
  // ----
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    {rst_b, reg_addr, reg_wr_data, reg_wr_en, reg_rd_en} = '0;
    {run_port_clock_gate, sleep_port_clock_gate, port_access_req} = '0;
    capability_mask_1 = 32'h0000_0000;
    power_mode = PCG_MODE_RUN;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset_values;
    t_sw_reset;
    t_gating;
    t_fault_irq;
    end_of_test();
  end
endmodule
